// >>> src/biphase_pkg.sv
/*
  Shared constants, types and helpers for the serial audio link that feeds
  a biphase-mark transmitter, used by both the source end and the device end.
  Assumes a single 25 MHz reference clock on both ends.
*/
package biphase_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {FMT_I2S, FMT_LEFT_JUST, FMT_RIGHT_JUST} format_e;
    typedef enum logic [1:0] {WIDTH_16, WIDTH_18, WIDTH_20, WIDTH_24} width_e;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int REF_CLK_HZ = 25_000_000;
    localparam int BIT_HALF_CYCLES = 12;
    localparam int FRAME_SLOTS = 64;
    localparam int FRAME_CYCLES = FRAME_SLOTS * 2 * BIT_HALF_CYCLES;
    localparam int OSC_RATIO_HI = 384;
    localparam int OSC_RATIO_LO = 256;
    localparam int OSC_HALF_HI = FRAME_CYCLES / (2 * OSC_RATIO_HI);
    localparam int OSC_HALF_LO = FRAME_CYCLES / (2 * OSC_RATIO_LO);
    localparam int HALF_CELLS_PER_FRAME = 128;
    localparam int OSC_DIV_HI = OSC_RATIO_HI / HALF_CELLS_PER_FRAME;
    localparam int OSC_DIV_LO = OSC_RATIO_LO / HALF_CELLS_PER_FRAME;
    localparam int BLOCK_FRAMES = 192;

    // ------------------------------------------------------------------
    // Slot and field constants
    // ------------------------------------------------------------------
    localparam logic [5:0] SLOT_LAST = 6'h3F;
    localparam logic [5:0] HALF_SLOTS = 6'h20;
    localparam logic [5:0] MAX_WORD_BITS = 6'h18;
    localparam logic [5:0] BITS_16 = 6'h10;
    localparam logic [5:0] BITS_18 = 6'h12;
    localparam logic [5:0] BITS_20 = 6'h14;
    localparam logic [5:0] BITS_24 = 6'h18;
    localparam logic [5:0] I2S_MSB_SLOT = 6'h01;
    localparam logic [5:0] LJ_MSB_SLOT = 6'h00;
    localparam logic [6:0] HALF_CELL_LAST = 7'h7F;
    localparam logic [4:0] PREAMBLE_SLOTS = 5'h04;
    localparam logic [7:0] PRE_BLOCK = 8'hE8;
    localparam logic [7:0] PRE_LEFT = 8'hE2;
    localparam logic [7:0] PRE_RIGHT = 8'hE4;
    localparam int PIN_BCLK = 0;
    localparam int PIN_FS = 1;
    localparam int PIN_DATA = 2;
    localparam int PIN_OSC = 3;
    localparam int PIN_COUNT = 4;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [5:0] word_bits(width_e w);
        unique case (w)
            WIDTH_16: word_bits = BITS_16;
            WIDTH_18: word_bits = BITS_18;
            WIDTH_20: word_bits = BITS_20;
            WIDTH_24: word_bits = BITS_24;
        endcase
    endfunction : word_bits

    function automatic logic [5:0] msb_slot(format_e f, width_e w);
        unique case (f)
            FMT_I2S: msb_slot = I2S_MSB_SLOT;
            FMT_LEFT_JUST: msb_slot = LJ_MSB_SLOT;
            FMT_RIGHT_JUST: msb_slot = HALF_SLOTS - word_bits(w);
            default: msb_slot = I2S_MSB_SLOT;
        endcase
    endfunction : msb_slot

    function automatic logic frame_is_left(format_e f, logic fs);
        frame_is_left = (f == FMT_LEFT_JUST || f == FMT_RIGHT_JUST) ? fs : ~fs;
    endfunction : frame_is_left

endpackage : biphase_pkg

// >>> src/audio_link_if.sv
/*
  Serial audio link between the source end and the device end.
  Assumes the bench joins the two modports; all lines are one-way.
*/
interface audio_link_if;
    logic bit_clk;
    logic frame_sync;
    logic serial_sample_data;
    logic oversampling_clock;

    modport source (
        output bit_clk,
        output frame_sync,
        output serial_sample_data,
        output oversampling_clock
    );

    modport device (
        input bit_clk,
        input frame_sync,
        input serial_sample_data,
        input oversampling_clock
    );
endinterface : audio_link_if

// >>> src/serial_audio_source.sv
/*
  Source end: makes bit clock, frame sync, serial data and the oversampling
  clock from ref_clk, and serialises a left/right pair each frame.
  Assumes samples are left-aligned in 24 bits and held until sample_req.
*/
module serial_audio_source
    import biphase_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    audio_link_if.source link,
    input wire format_e format,
    input wire width_e width,
    input wire logic osc_ratio_384,
    input wire logic [23:0] left_sample,
    input wire logic [23:0] right_sample,
    output logic sample_req
);

    // ------------------------------------------------------------------
    // Bit clock divider
    // ------------------------------------------------------------------
    localparam logic [4:0] HALF_LAST = 5'(BIT_HALF_CYCLES - 1);
    logic [4:0] half_cnt_q;
    logic bclk_q;
    logic fall;

    assign fall = (half_cnt_q == HALF_LAST) && bclk_q;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            half_cnt_q <= 5'h00;
            bclk_q <= 1'b0;
        end else if (half_cnt_q == HALF_LAST) begin
            half_cnt_q <= 5'h00;
            bclk_q <= ~bclk_q;
        end else begin
            half_cnt_q <= half_cnt_q + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // Frame position and serial data
    // ------------------------------------------------------------------
    logic [5:0] pos_q;
    logic [5:0] npos;
    logic [5:0] k;
    logic [5:0] first;
    logic [5:0] rel;
    logic [23:0] word_l_q;
    logic [23:0] word_r_q;
    logic [23:0] word;
    logic fs_q;
    logic data_q;
    logic req_q;
    logic bit_n;

    assign npos = pos_q + 6'h01;
    assign k = {1'b0, npos[4:0]};
    assign first = msb_slot(format, width);
    assign rel = k - first;

    always_comb begin
        if (npos[5]) begin
            word = word_r_q;
        end else if (npos == 6'h00) begin
            word = left_sample;
        end else begin
            word = word_l_q;
        end
        bit_n = 1'b0;
        if ((k >= first) && (rel < word_bits(width))) begin
            bit_n = word[5'(MAX_WORD_BITS - 6'h01 - rel)];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pos_q <= SLOT_LAST;
            fs_q <= 1'b0;
            data_q <= 1'b0;
            word_l_q <= 24'h000000;
            word_r_q <= 24'h000000;
            req_q <= 1'b0;
        end else begin
            req_q <= fall && (npos == 6'h00);
            if (fall) begin
                pos_q <= npos;
                fs_q <= npos[5] ^ ~frame_is_left(format, 1'b0);
                data_q <= bit_n;
                if (npos == 6'h00) begin
                    word_l_q <= left_sample;
                    word_r_q <= right_sample;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Oversampling clock
    // ------------------------------------------------------------------
    localparam logic [1:0] OSC_LAST_HI = 2'(OSC_HALF_HI - 1);
    localparam logic [1:0] OSC_LAST_LO = 2'(OSC_HALF_LO - 1);
    logic [1:0] osc_cnt_q;
    logic osc_q;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            osc_cnt_q <= 2'h0;
            osc_q <= 1'b0;
        end else if (osc_cnt_q == (osc_ratio_384 ? OSC_LAST_HI : OSC_LAST_LO)) begin
            osc_cnt_q <= 2'h0;
            osc_q <= ~osc_q;
        end else begin
            osc_cnt_q <= osc_cnt_q + 2'h1;
        end
    end

    assign link.bit_clk = bclk_q;
    assign link.frame_sync = fs_q;
    assign link.serial_sample_data = data_q;
    assign link.oversampling_clock = osc_q;
    assign sample_req = req_q;

endmodule : serial_audio_source

// >>> src/biphase_tx_serial_input.sv
/*
  Device end: samples the serial audio link, recovers left and right words,
  divides the oversampling clock to a half-cell tick and sends the pair as
  biphase-mark subframes.
  Assumes link pins are asynchronous to ref_clk and slow enough to be
  oversampled after a two-flop synchroniser.
*/
module biphase_tx_serial_input
    import biphase_pkg::*;
#(
    parameter int BLOCK_LEN = BLOCK_FRAMES
)
(
    input wire logic ref_clk,
    input wire logic rstn,
    audio_link_if.device link,
    input wire format_e format,
    input wire width_e width,
    input wire logic osc_ratio_384,
    output logic [23:0] left_sample,
    output logic [23:0] right_sample,
    output logic sample_valid,
    output logic framing_slip,
    output logic biphase_clk,
    output logic biphase_out
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    wire logic [PIN_COUNT-1:0] pin_raw;
    wire logic [PIN_COUNT-1:0] pin_sync;

    assign pin_raw[PIN_BCLK] = link.bit_clk;
    assign pin_raw[PIN_FS] = link.frame_sync;
    assign pin_raw[PIN_DATA] = link.serial_sample_data;
    assign pin_raw[PIN_OSC] = link.oversampling_clock;

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
            logic meta_q;
            logic stable_q;
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    meta_q <= 1'b0;
                    stable_q <= 1'b0;
                end else begin
                    meta_q <= pin_raw[gi];
                    stable_q <= meta_q;
                end
            end
            assign pin_sync[gi] = stable_q;
        end
    endgenerate

    logic bclk_s;
    logic fs_s;
    logic data_s;
    logic osc_s;

    assign bclk_s = pin_sync[PIN_BCLK];
    assign fs_s = pin_sync[PIN_FS];
    assign data_s = pin_sync[PIN_DATA];
    assign osc_s = pin_sync[PIN_OSC];

    // ------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------
    logic bclk_prev_q;
    logic osc_prev_q;
    logic bclk_rise;
    logic osc_rise;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bclk_prev_q <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            bclk_prev_q <= bclk_s;
            osc_prev_q <= osc_s;
        end
    end

    assign bclk_rise = bclk_s && !bclk_prev_q;
    assign osc_rise = osc_s && !osc_prev_q;

    // ------------------------------------------------------------------
    // Slot tracking and word capture
    // ------------------------------------------------------------------
    logic fs_last_q;
    logic [5:0] slot_q;
    logic [23:0] shift_q;
    logic [23:0] left_q;
    logic [23:0] right_q;
    logic valid_q;
    logic slip_q;
    logic edge_now;
    logic [5:0] k_now;
    logic [5:0] first_n;
    logic [5:0] bits_n;
    logic [5:0] k_rel;
    logic in_win;
    logic word_end;
    logic is_left;
    logic [23:0] word_full;

    always_comb begin
        edge_now = fs_s != fs_last_q;
        k_now = edge_now ? 6'h00 : slot_q;
        first_n = msb_slot(format, width);
        bits_n = word_bits(width);
        k_rel = k_now - first_n;
        in_win = (k_now >= first_n) && (k_rel < bits_n);
        word_end = in_win && (k_rel == bits_n - 6'h01);
        is_left = frame_is_left(format, fs_s);
        word_full = {shift_q[22:0], data_s} << (MAX_WORD_BITS - bits_n);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fs_last_q <= 1'b0;
            slot_q <= 6'h00;
            slip_q <= 1'b0;
        end else begin
            slip_q <= 1'b0;
            if (bclk_rise) begin
                fs_last_q <= fs_s;
                slot_q <= (k_now == SLOT_LAST) ? k_now : k_now + 6'h01;
                slip_q <= edge_now && (slot_q != HALF_SLOTS);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            shift_q <= 24'h000000;
        end else if (bclk_rise && in_win) begin
            shift_q <= {shift_q[22:0], data_s};
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            left_q <= 24'h000000;
            right_q <= 24'h000000;
            valid_q <= 1'b0;
        end else begin
            valid_q <= bclk_rise && word_end && !is_left;
            if (bclk_rise && word_end) begin
                if (is_left) begin
                    left_q <= word_full;
                end else begin
                    right_q <= word_full;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Biphase clock divider
    // ------------------------------------------------------------------
    localparam logic [1:0] DIV_LAST_HI = 2'(OSC_DIV_HI - 1);
    localparam logic [1:0] DIV_LAST_LO = 2'(OSC_DIV_LO - 1);
    localparam logic [7:0] BLOCK_LAST = 8'(BLOCK_LEN - 1);
    logic [1:0] div_q;
    logic tick;
    logic bclk_out_q;

    assign tick = osc_rise && (div_q == (osc_ratio_384 ? DIV_LAST_HI : DIV_LAST_LO));

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_q <= 2'h0;
            bclk_out_q <= 1'b0;
        end else if (osc_rise) begin
            div_q <= tick ? 2'h0 : div_q + 2'h1;
            if (tick) begin
                bclk_out_q <= ~bclk_out_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Subframe sequencing
    // ------------------------------------------------------------------
    function automatic logic [31:0] build_subframe(logic [23:0] s);
        logic [31:0] v;
        v = {4'h0, s, 4'h0};
        v[31] = ^v[30:4];
        return v;
    endfunction : build_subframe

    logic [6:0] hc_q;
    logic [7:0] block_q;
    logic [23:0] tx_l_q;
    logic [23:0] tx_r_q;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hc_q <= 7'h00;
            block_q <= 8'h00;
            tx_l_q <= 24'h000000;
            tx_r_q <= 24'h000000;
        end else if (tick) begin
            hc_q <= hc_q + 7'h01;
            if (hc_q == HALF_CELL_LAST) begin
                block_q <= (block_q == BLOCK_LAST) ? 8'h00 : block_q + 8'h01;
                tx_l_q <= left_q;
                tx_r_q <= right_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Biphase-mark encoder
    // ------------------------------------------------------------------
    logic line_q;
    logic inv_q;
    logic [4:0] slot5;
    logic half;
    logic [31:0] sub;
    logic [7:0] pat;
    logic inv_now;
    logic level;

    always_comb begin
        slot5 = hc_q[5:1];
        half = hc_q[0];
        sub = hc_q[6] ? build_subframe(tx_r_q) : build_subframe(tx_l_q);
        if (hc_q[6]) begin
            pat = PRE_RIGHT;
        end else if (block_q == 8'h00) begin
            pat = PRE_BLOCK;
        end else begin
            pat = PRE_LEFT;
        end
        inv_now = ((slot5 == 5'h00) && !half) ? line_q : inv_q;
        if (slot5 < PREAMBLE_SLOTS) begin
            level = pat[3'(3'h7 - {slot5[1:0], half})] ^ inv_now;
        end else if (!half) begin
            level = ~line_q;
        end else begin
            level = line_q ^ sub[slot5];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            line_q <= 1'b0;
            inv_q <= 1'b0;
        end else if (tick) begin
            line_q <= level;
            inv_q <= inv_now;
        end
    end

    assign left_sample = left_q;
    assign right_sample = right_q;
    assign sample_valid = valid_q;
    assign framing_slip = slip_q;
    assign biphase_clk = bclk_out_q;
    assign biphase_out = line_q;

endmodule : biphase_tx_serial_input

// >>> tb/audio_link_sva.sv
/*
  Assertion checker for the serial audio link between the two ends.
  Assumes every link line comes from a ref_clk flop cleared by rstn.
*/
module audio_link_sva (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic bit_clk,
    input wire logic frame_sync,
    input wire logic serial_sample_data,
    input wire logic oversampling_clock
);
    // ----------
    // Edge tracking
    // ----------
    logic bclk_q, fs_q, osc_q, bclk_seen_q, fs_seen_q, osc_seen_q;
    logic bclk_chg, fs_chg, osc_chg, bclk_rise, osc_rise;
    logic [3:0] bclk_cnt_q;
    logic [9:0] fs_cnt_q;
    logic [6:0] rise_cnt_q;
    logic [7:0] osc_rise_q;
    logic [1:0] osc_cnt_q;

    assign bclk_chg = bit_clk != bclk_q;
    assign fs_chg = frame_sync != fs_q;
    assign osc_chg = oversampling_clock != osc_q;
    assign bclk_rise = bit_clk & ~bclk_q;
    assign osc_rise = oversampling_clock & ~osc_q;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bclk_q <= 1'b0;
            bclk_seen_q <= 1'b0;
            bclk_cnt_q <= 4'h0;
        end else begin
            bclk_q <= bit_clk;
            bclk_seen_q <= bclk_seen_q | bclk_chg;
            bclk_cnt_q <= bclk_chg ? 4'h0 : bclk_cnt_q + {3'h0, bclk_cnt_q != 4'hF};
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fs_q <= 1'b0;
            fs_seen_q <= 1'b0;
            fs_cnt_q <= 10'h000;
            rise_cnt_q <= 7'h00;
            osc_rise_q <= 8'h00;
        end else begin
            fs_q <= frame_sync;
            fs_seen_q <= fs_seen_q | fs_chg;
            fs_cnt_q <= fs_chg ? 10'h000 : fs_cnt_q + {9'h000, fs_cnt_q != 10'h3FF};
            rise_cnt_q <= (fs_chg ? 7'h00 : rise_cnt_q) + {6'h00, bclk_rise};
            osc_rise_q <= (fs_chg ? 8'h00 : osc_rise_q) + {7'h00, osc_rise};
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            osc_q <= 1'b0;
            osc_seen_q <= 1'b0;
            osc_cnt_q <= 2'h0;
        end else begin
            osc_q <= oversampling_clock;
            osc_seen_q <= osc_seen_q | osc_chg;
            osc_cnt_q <= osc_chg ? 2'h0 : osc_cnt_q + {1'b0, osc_cnt_q != 2'h3};
        end
    end

    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    AST_BCLK_HALF: assert property (bclk_chg && bclk_seen_q |-> bclk_cnt_q == 4'hB)
        else $error("bit clock half period wrong");
    AST_FS_SETUP: assert property ($changed(frame_sync) |-> (!bit_clk)[*8])
        else $error("frame sync moved too close to a bit clock rise");
    AST_DATA_SETUP: assert property ($changed(serial_sample_data) |-> (!bit_clk)[*8])
        else $error("serial data moved too close to a bit clock rise");
    AST_CAPTURE_HOLD: assert property (
        $rose(bit_clk) |=> $stable({frame_sync, serial_sample_data})[*8])
        else $error("link lines not held after bit clock rise");
    AST_FS_SPACING: assert property (fs_chg && fs_seen_q |-> fs_cnt_q == 10'h2FF)
        else $error("frame sync half period wrong");
    AST_FS_DUE: assert property (fs_seen_q && fs_cnt_q == 10'h2FF |-> fs_chg)
        else $error("frame sync missed its edge");
    AST_BITS_PER_HALF: assert property (fs_chg && fs_seen_q |-> rise_cnt_q == 7'h20)
        else $error("bit periods per channel half not 32");
    AST_OSC_HALF: assert property (
        osc_chg && osc_seen_q |-> osc_cnt_q inside {2'h1, 2'h2})
        else $error("oversampling clock half period wrong");
    AST_OSC_PER_HALF: assert property (
        fs_chg && fs_seen_q |-> osc_rise_q inside {8'hC0, 8'h80})
        else $error("oversampling rises per channel half wrong");

    cover property (fs_chg && fs_seen_q);
    cover property (osc_chg && osc_seen_q && osc_cnt_q == 2'h1);
    cover property (osc_chg && osc_seen_q && osc_cnt_q == 2'h2);
    cover property ($rose(bit_clk) && serial_sample_data);
endmodule : audio_link_sva

// >>> tb/biphase_tx_serial_input_test.sv
/*
  Self-checking bench: source end and device end joined by the link.
  Assumes both ends take the same format, width and ratio settings.
*/
`define CHECK(got, exp) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end

module biphase_tx_serial_input_test
    import biphase_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------
    // Stimulus table
    // ----------
    typedef struct {
        format_e fmt;
        width_e wid;
        logic osc;
        logic [23:0] l, r, el, er;
    } row_s;
    row_s rows [8] = '{
        '{FMT_I2S, WIDTH_16, 1'b1, 24'hA5C3F1, 24'h5A3C0E, 24'hA5C300, 24'h5A3C00},
        '{FMT_I2S, WIDTH_24, 1'b0, 24'hFFFFFF, 24'h800001, 24'hFFFFFF, 24'h800001},
        '{FMT_LEFT_JUST, WIDTH_18, 1'b1, 24'h123456, 24'hFEDCBA, 24'h123440, 24'hFEDC80},
        '{FMT_LEFT_JUST, WIDTH_20, 1'b0, 24'h000000, 24'hC0FFEE, 24'h000000, 24'hC0FFE0},
        '{FMT_RIGHT_JUST, WIDTH_16, 1'b0, 24'h7F8001, 24'h0180FE, 24'h7F8000, 24'h018000},
        '{FMT_RIGHT_JUST, WIDTH_20, 1'b1, 24'hDEADBE, 24'h2468AC, 24'hDEADB0, 24'h2468A0},
        '{FMT_RIGHT_JUST, WIDTH_24, 1'b1, 24'h13579B, 24'hECA864, 24'h13579B, 24'hECA864},
        '{FMT_RIGHT_JUST, WIDTH_18, 1'b0, 24'h3C3C3C, 24'hC3C3C3, 24'h3C3C00, 24'hC3C3C0}
    };

    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    format_e format = FMT_I2S;
    width_e width = WIDTH_16;
    logic osc_ratio_384 = 1'b0;
    logic [23:0] src_left = 24'h000000;
    logic [23:0] src_right = 24'h000000;
    logic sample_req, sample_valid, framing_slip, biphase_clk, biphase_out;
    logic [23:0] left_sample, right_sample;
    int failures = 0;
    int n_tests = 0;
    int slips = 0;
    int reqs = 0;
    int tick_n = 0;
    int hc_n = 0;
    logic rec_on = 1'b0;
    logic bpc_q = 1'b0;
    logic hc [384];

    always #20 ref_clk = ~ref_clk;

    audio_link_if link ();

    serial_audio_source serial_audio_source_inst (
        .ref_clk(ref_clk), .rstn(rstn), .link(link), .format(format), .width(width),
        .osc_ratio_384(osc_ratio_384), .left_sample(src_left), .right_sample(src_right),
        .sample_req(sample_req)
    );

    biphase_tx_serial_input #(.BLOCK_LEN(4)) biphase_tx_serial_input_inst (
        .ref_clk(ref_clk), .rstn(rstn), .link(link), .format(format), .width(width),
        .osc_ratio_384(osc_ratio_384), .left_sample(left_sample),
        .right_sample(right_sample), .sample_valid(sample_valid),
        .framing_slip(framing_slip), .biphase_clk(biphase_clk), .biphase_out(biphase_out)
    );

    audio_link_sva audio_link_sva_inst (
        .ref_clk(ref_clk), .rstn(rstn), .bit_clk(link.bit_clk),
        .frame_sync(link.frame_sync), .serial_sample_data(link.serial_sample_data),
        .oversampling_clock(link.oversampling_clock)
    );

    // ----------
    // Half-cell recorder
    // ----------
    always @(posedge ref_clk) begin
        bpc_q <= biphase_clk;
        if (biphase_clk !== bpc_q) begin
            tick_n++;
            if (rec_on && hc_n < 384) begin
                hc[hc_n] = biphase_out;
                hc_n++;
            end
        end
    end

    always @(negedge ref_clk) begin
        if (framing_slip === 1'b1) slips++;
        if (sample_req === 1'b1) reqs++;
    end

    function automatic logic [7:0] pre(int a);
        for (int k = 0; k < 8; k++) pre[7 - k] = hc[a + k];
    endfunction : pre

    function automatic logic [24:0] dec(int a);
        dec = 25'h0000000;
        for (int k = 0; k < 28; k++) begin
            if (k < 24) dec[k] = hc[a + 2 * k] ^ hc[a + 2 * k + 1];
            dec[24] ^= hc[a + 2 * k] ^ hc[a + 2 * k + 1];
        end
    endfunction : dec

    // ----------
    // Tasks
    // ----------
    task automatic wait_valid();
        int n;
        n = 0;
        @(negedge ref_clk);
        while (sample_valid !== 1'b1 && n < 4000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 4000) begin
            failures++;
            $display("ERROR %0t: no sample pair", $time);
        end
    endtask : wait_valid

    task automatic run_row(row_s r, int hold);
        int k, bits, s, m;
        logic prev, fs_left;
        logic [31:0] wb;
        bits = (r.wid == WIDTH_24) ? 24 : 16 + 2 * int'(r.wid);
        m = (r.fmt == FMT_RIGHT_JUST) ? 32 - bits : (r.fmt == FMT_LEFT_JUST) ? 0 : 1;
        @(posedge ref_clk);
        rstn <= 1'b0;
        format <= r.fmt;
        width <= r.wid;
        osc_ratio_384 <= r.osc;
        src_left <= r.l;
        src_right <= r.r;
        repeat (hold) @(posedge ref_clk);
        rstn <= 1'b1;
        slips = 0;
        k = -1;
        prev = 1'b0;
        wb = 32'h00000000;
        fs_left = (r.fmt == FMT_LEFT_JUST || r.fmt == FMT_RIGHT_JUST);
        repeat (900) begin
            @(negedge ref_clk);
            if (link.bit_clk === 1'b1 && prev === 1'b0) begin
                if (k == 0) `CHECK(link.frame_sync, fs_left)
                if (k >= 0 && k < 32) wb[31 - k] = link.serial_sample_data;
                k++;
            end
            prev = link.bit_clk;
        end
        `CHECK(wb, {r.el, 8'h00} >> m);
        wait_valid();
        wait_valid();
        hc_n = 0;
        rec_on = 1'b1;
        k = tick_n;
        reqs = 0;
        wait_valid();
        `CHECK(left_sample, r.el);
        `CHECK(right_sample, r.er);
        `CHECK(tick_n - k, 128);
        `CHECK(reqs, 1);
        `CHECK(slips, 1);
        k = 0;
        while (hc_n < 384 && k < 5000) begin
            @(negedge ref_clk);
            k++;
        end
        rec_on = 1'b0;
        `CHECK(hc_n, 384);
        s = 129;
        while (s < 256 && !(pre(s) inside {8'hE8, 8'hE2, 8'h17, 8'h1D})) s++;
        `CHECK(pre(s + 64) inside {8'hE4, 8'h1B}, 1'b1);
        `CHECK(dec(s + 8), {1'b0, r.el});
        `CHECK(dec(s + 72), {1'b0, r.er});
        $display("row done format %0d width %0d", r.fmt, r.wid);
    endtask : run_row

    task conclude();
        $display("comparisons %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    // ----------
    // Main sequence
    // ----------
    initial begin
        for (int i = 0; i < 8; i++) run_row(rows[i], i == 0 ? 12 : 2);
        repeat (300) @(posedge ref_clk);
        rstn <= 1'b0;
        @(negedge ref_clk);
        `CHECK({sample_valid, framing_slip, biphase_clk, biphase_out, left_sample, right_sample,
                link.bit_clk, link.frame_sync, link.serial_sample_data,
                link.oversampling_clock, sample_req}, 57'h0);
        $display("mid-run reset done");
        run_row('{format_e'(2'h3), WIDTH_24, 1'b0, 24'h9669A5, 24'h0F0F0F, 24'h9669A5,
                  24'h0F0F0F}, 4);
        conclude();
    end

    initial begin
        repeat (90000) @(posedge ref_clk);
        failures++;
        $display("ERROR %0t: watchdog expired", $time);
        conclude();
    end
endmodule : biphase_tx_serial_input_test
